// *** dfas_cfg.svh ***
`ifndef DFAS_CFG_SVH
`define DFAS_CFG_SVH

// Function codes
`define DFAS_FN_ADD   4'h4
`define DFAS_FN_SUB   4'h7
// Field lengths
`define DFAS_LEN_ZERO 4'h0
`define DFAS_LEN_TEN  4'ha
`define DFAS_LEN_ONE  4'h1
// Digit arithmetic
`define DFAS_DIG_ZERO 4'h0
`define DFAS_BCD_MAX  5'h09
`define DFAS_CORR_ADD 4'h6
`define DFAS_CORR_SUB 4'ha
// Character layout
`define DFAS_NUM_HI   3
`define DFAS_ZONE5    4
`define DFAS_ZONE7    5
// Address width helpers
`define DFAS_ADDR_ONE 14'h0001

`endif

// *** dfas_pkg.sv ***
package dfas_pkg;

  typedef logic [3:0]  dfas_digit_t;
  typedef logic [5:0]  dfas_char_t;
  typedef logic [13:0] dfas_addr_t;

  typedef enum logic [3:0] {
    DFAS_IDLE = 4'h0,
    DFAS_POS  = 4'h1,
    DFAS_RDA  = 4'h3,
    DFAS_RDB  = 4'h2,
    DFAS_SIGN = 4'h6,
    DFAS_CALC = 4'h7,
    DFAS_WRB  = 4'h5,
    DFAS_FIN  = 4'h4,
    DFAS_DONE = 4'hc
  } dfas_state_t;

endpackage

// *** dfas_add_if.sv ***
`timescale 1ns/1ps
interface dfas_add_if;
  import dfas_pkg::*;
  dfas_digit_t d;
  dfas_digit_t h;
  logic        cin;
  logic        sub;
  dfas_digit_t sum;
  logic        cout;
  logic [4:0]  raw;

  modport core (output d, h, cin, sub, input sum, cout, raw);
  modport alu  (input d, h, cin, sub, output sum, cout, raw);
endinterface

// *** dfas_digit_adder.sv ***
`timescale 1ns/1ps
`include "dfas_cfg.svh"
module dfas_digit_adder import dfas_pkg::*; (
  dfas_add_if.alu io
);

  dfas_digit_t d_in;
  logic        over9;
  dfas_digit_t corr;

  // First adder, subtrahend inverted
  always_comb begin
    d_in   = io.sub ? ~io.d : io.d;
    io.raw = {1'b0, d_in} + {1'b0, io.h} + {4'h0, io.cin};
  end

  // Correction factor gating and carry onward
  always_comb begin
    over9 = io.raw > `DFAS_BCD_MAX;
    if (!io.sub) begin
      corr    = over9 ? `DFAS_CORR_ADD : `DFAS_DIG_ZERO;
      io.cout = over9;
    end else begin
      corr    = io.raw[4] ? `DFAS_DIG_ZERO : `DFAS_CORR_SUB;
      io.cout = io.raw[4];
    end
  end

  // Second adder, carry dropped
  always_comb begin
    io.sum = io.raw[3:0] + corr;
  end

endmodule

// *** dfas_top.sv ***
// What this block does
// - Subtract flop starts set for subtract code, cleared for add code.
// - Length value zero means ten digits, for both fields.
// - Result overwrites B field; A field is never written.
// - Result LSD: bit 7 holds sign, bit 5 forced one; other zones kept.
// - Each operand with LSD bit 7 set toggles subtract; sign starts as B's.
// - Pointers move to LSDs first, then digits proceed toward MSD.
// - Only numeric bits enter the adder; zones bypass it.
// - In add, raw sums above nine get six added once.
// - Raw carry is fed into correction; in subtract it becomes the digit carry, in add the carry is raw above nine.
// - Subtract adds fifteens complement of A; carry preset; no carry means borrow.
// - In subtract, a negative digit is corrected by adding ten.
// - A borrowing digit clears carry regardless of binary carry.
// - Carry clear at end: flip sign and condition, replace B by zero minus B.
// - Overflow only after effective add; dropped leading one, rest kept.
// - Short A acts as zero padded to B length.
// - Long A stops at B length; overflow only from carry beyond result.
// - Conditions: minus, zero, plus via zero/minus flops; overflow via carry.
// - Digit registers and carry feed first adder; A inverted when subtracting, B instead in the recomplement pass.
// - Second adder adds gated correction, drives sum; its carry dropped.
`timescale 1ns/1ps
`include "dfas_cfg.svh"
module dfas_top import dfas_pkg::*; (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Instruction
  input  wire logic        start,
  input  wire logic [3:0]  func_code,
  input  wire logic [3:0]  a_length_field,
  input  wire logic [3:0]  b_length_field,
  input  wire dfas_addr_t  a_addr,
  input  wire dfas_addr_t  b_addr,
  // Core memory
  output logic             mem_req,
  output logic             mem_we,
  output dfas_addr_t       mem_addr,
  output dfas_char_t       mem_wdata,
  input  wire logic        mem_ack,
  input  wire dfas_char_t  mem_rdata,
  // Status
  output logic             busy,
  output logic             done,
  output logic             cond_zero,
  output logic             cond_minus,
  output logic             cond_carry
);

  logic        rst_s1_r;
  logic        rst_n;
  dfas_state_t st_r;
  logic        sub_r;
  logic        carry_r;
  logic        sign_r;
  logic        recomp_r;
  logic        nz_r;
  dfas_digit_t a_len_r;
  dfas_digit_t b_len_r;
  dfas_digit_t idx_r;
  dfas_addr_t  a_lsd_r;
  dfas_addr_t  b_lsd_r;
  dfas_char_t  a_chr_r;
  dfas_char_t  b_chr_r;
  logic        go;
  logic        last;
  logic        use_a;
  dfas_digit_t a_len_nxt;
  dfas_digit_t b_len_nxt;
  dfas_char_t  wdata_nxt;

  dfas_add_if add_io ();

  dfas_digit_adder u_adder (
    .io (add_io)
  );

  // Reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Decode
  always_comb begin
    go        = start && (func_code == `DFAS_FN_ADD || func_code == `DFAS_FN_SUB);
    a_len_nxt = (a_length_field == `DFAS_LEN_ZERO) ? `DFAS_LEN_TEN : a_length_field;
    b_len_nxt = (b_length_field == `DFAS_LEN_ZERO) ? `DFAS_LEN_TEN : b_length_field;
    last      = idx_r == b_len_r - `DFAS_LEN_ONE;
    use_a     = !recomp_r && idx_r < a_len_r;
  end

  // Adder operands
  always_comb begin
    add_io.sub = sub_r;
    add_io.cin = carry_r;
    if (recomp_r) begin
      add_io.d = b_chr_r[`DFAS_NUM_HI:0];
      add_io.h = `DFAS_DIG_ZERO;
    end else begin
      add_io.d = use_a ? a_chr_r[`DFAS_NUM_HI:0] : `DFAS_DIG_ZERO;
      add_io.h = b_chr_r[`DFAS_NUM_HI:0];
    end
  end

  // Result character
  always_comb begin
    wdata_nxt = {b_chr_r[`DFAS_ZONE7:`DFAS_ZONE5], add_io.sum};
    if (idx_r == `DFAS_DIG_ZERO) begin
      wdata_nxt[`DFAS_ZONE7] = sign_r;
      wdata_nxt[`DFAS_ZONE5] = 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= DFAS_IDLE;
    end else begin
      unique case (st_r)
        DFAS_IDLE: if (go) st_r <= DFAS_POS;
        DFAS_POS:  st_r <= DFAS_RDA;
        DFAS_RDA:  if (mem_req && mem_ack) st_r <= DFAS_RDB;
        DFAS_RDB: begin
          if (mem_req && mem_ack) begin
            st_r <= (idx_r == `DFAS_DIG_ZERO && !recomp_r) ? DFAS_SIGN : DFAS_CALC;
          end
        end
        DFAS_SIGN: st_r <= DFAS_CALC;
        DFAS_CALC: st_r <= DFAS_WRB;
        DFAS_WRB: begin
          if (mem_req && mem_ack) begin
            if (last) begin
              st_r <= DFAS_FIN;
            end else begin
              st_r <= (!recomp_r && idx_r + `DFAS_LEN_ONE < a_len_r) ? DFAS_RDA : DFAS_RDB;
            end
          end
        end
        DFAS_FIN: begin
          if (sub_r && !carry_r && !recomp_r) begin
            st_r <= DFAS_RDB;
          end else begin
            st_r <= DFAS_DONE;
          end
        end
        DFAS_DONE: st_r <= DFAS_IDLE;
        default:   st_r <= DFAS_IDLE;
      endcase
    end
  end

  // Operand setup and pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_len_r <= `DFAS_LEN_TEN;
      b_len_r <= `DFAS_LEN_TEN;
      a_lsd_r <= '0;
      b_lsd_r <= '0;
    end else if (st_r == DFAS_IDLE && go) begin
      a_len_r <= a_len_nxt;
      b_len_r <= b_len_nxt;
      a_lsd_r <= a_addr + {10'h000, a_len_nxt} - `DFAS_ADDR_ONE;
      b_lsd_r <= b_addr + {10'h000, b_len_nxt} - `DFAS_ADDR_ONE;
    end
  end

  // Digit index
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= '0;
    end else if (st_r == DFAS_IDLE) begin
      idx_r <= '0;
    end else if (st_r == DFAS_WRB && mem_req && mem_ack && !last) begin
      idx_r <= idx_r + `DFAS_LEN_ONE;
    end else if (st_r == DFAS_FIN) begin
      idx_r <= '0;
    end
  end

  // Operation, sign and carry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sub_r    <= 1'b0;
      carry_r  <= 1'b0;
      sign_r   <= 1'b0;
      recomp_r <= 1'b0;
    end else begin
      unique case (st_r)
        DFAS_IDLE: begin
          if (go) begin
            sub_r    <= func_code == `DFAS_FN_SUB;
            recomp_r <= 1'b0;
          end
        end
        DFAS_SIGN: begin
          sub_r   <= sub_r ^ a_chr_r[`DFAS_ZONE7] ^ b_chr_r[`DFAS_ZONE7];
          carry_r <= sub_r ^ a_chr_r[`DFAS_ZONE7] ^ b_chr_r[`DFAS_ZONE7];
          sign_r  <= b_chr_r[`DFAS_ZONE7];
        end
        DFAS_CALC: carry_r <= add_io.cout;
        DFAS_FIN: begin
          if (sub_r && !carry_r && !recomp_r) begin
            recomp_r <= 1'b1;
            sign_r   <= ~sign_r;
            carry_r  <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Memory requests
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      a_chr_r   <= '0;
      b_chr_r   <= '0;
    end else begin
      unique case (st_r)
        DFAS_RDA: begin
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            a_chr_r <= mem_rdata;
          end else if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= a_lsd_r - {10'h000, idx_r};
          end
        end
        DFAS_RDB: begin
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            b_chr_r <= mem_rdata;
          end else if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= b_lsd_r - {10'h000, idx_r};
          end
        end
        DFAS_CALC: begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= b_lsd_r - {10'h000, idx_r};
          mem_wdata <= wdata_nxt;
        end
        DFAS_WRB: begin
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
          end
        end
        default: begin
          mem_req <= 1'b0;
          mem_we  <= 1'b0;
        end
      endcase
    end
  end

  // Non-zero tracking per pass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nz_r <= 1'b0;
    end else if (st_r == DFAS_IDLE || st_r == DFAS_FIN) begin
      nz_r <= 1'b0;
    end else if (st_r == DFAS_CALC && add_io.sum != `DFAS_DIG_ZERO) begin
      nz_r <= 1'b1;
    end
  end

  // Condition flops and completion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cond_zero  <= 1'b0;
      cond_minus <= 1'b0;
      cond_carry <= 1'b0;
      done       <= 1'b0;
      busy       <= 1'b0;
    end else begin
      done <= st_r == DFAS_FIN && !(sub_r && !carry_r && !recomp_r);
      busy <= (st_r != DFAS_IDLE || go) && st_r != DFAS_DONE;
      if (st_r == DFAS_FIN && !(sub_r && !carry_r && !recomp_r)) begin
        cond_zero  <= !nz_r;
        cond_minus <= nz_r && sign_r;
        cond_carry <= !sub_r && carry_r;
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_overdraft;
    st_r == DFAS_FIN && sub_r && !carry_r && !recomp_r;
  endsequence

  sequence s_sign_flip;
    recomp_r && st_r == DFAS_RDB;
  endsequence

  property p_sub_start;
    (st_r == DFAS_IDLE && go) |=> sub_r == ($past(func_code) == `DFAS_FN_SUB);
  endproperty
  a_sub_start: assert property (p_sub_start) else $error("subtract flop start wrong");

  property p_len_ten;
    (st_r == DFAS_IDLE && go && b_length_field == `DFAS_LEN_ZERO) |=> b_len_r == `DFAS_LEN_TEN;
  endproperty
  a_len_ten: assert property (p_len_ten) else $error("zero length not ten");

  property p_wr_b_only;
    (mem_req && mem_we) |-> (b_lsd_r - mem_addr) < {10'h000, b_len_r};
  endproperty
  a_wr_b_only: assert property (p_wr_b_only) else $error("write outside B field");

  property p_lsd_zone;
    (mem_req && mem_we && idx_r == `DFAS_DIG_ZERO) |-> mem_wdata[`DFAS_ZONE5] && mem_wdata[`DFAS_ZONE7] == sign_r;
  endproperty
  a_lsd_zone: assert property (p_lsd_zone) else $error("LSD zone bits wrong");

  property p_sign_toggle;
    st_r == DFAS_SIGN |=> sub_r == ($past(sub_r) ^ $past(a_chr_r[`DFAS_ZONE7]) ^ $past(b_chr_r[`DFAS_ZONE7]))
                          && carry_r == sub_r;
  endproperty
  a_sign_toggle: assert property (p_sign_toggle) else $error("sign toggle wrong");

  property p_first_lsd;
    st_r == DFAS_POS |=> ##1 mem_req && mem_addr == a_lsd_r;
  endproperty
  a_first_lsd: assert property (p_first_lsd) else $error("first read not at LSD");
  property p_a_in_field;
    (st_r == DFAS_RDA && mem_req) |-> idx_r < a_len_r;
  endproperty
  a_a_in_field: assert property (p_a_in_field) else $error("A read beyond A field");

  property p_zone_bypass;
    (mem_req && mem_we && idx_r != `DFAS_DIG_ZERO) |-> mem_wdata[`DFAS_ZONE7:`DFAS_ZONE5] == b_chr_r[`DFAS_ZONE7:`DFAS_ZONE5];
  endproperty
  a_zone_bypass: assert property (p_zone_bypass) else $error("zone bits altered");

  property p_add_corr;
    (st_r == DFAS_CALC && !sub_r && add_io.raw > `DFAS_BCD_MAX) |=>
      mem_wdata[`DFAS_NUM_HI:0] == $past(add_io.raw[3:0]) + `DFAS_CORR_ADD && carry_r;
  endproperty
  a_add_corr: assert property (p_add_corr) else $error("add correction wrong");

  property p_borrow;
    (st_r == DFAS_CALC && sub_r && !add_io.raw[4]) |=>
      !carry_r && mem_wdata[`DFAS_NUM_HI:0] == $past(add_io.raw[3:0]) + `DFAS_CORR_SUB;
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow handling wrong");

  property p_recomp;
    s_overdraft |=> s_sign_flip ##0 sign_r != $past(sign_r) && carry_r;
  endproperty
  a_recomp: assert property (p_recomp) else $error("overdraft not recomplemented");

  property p_ovf;
    done && sub_r |-> !cond_carry;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow after subtract");

  property p_cond;
    done |-> !(cond_zero && cond_minus) && cond_zero == !$past(nz_r);
  endproperty
  a_cond: assert property (p_cond) else $error("condition encoding wrong");

endmodule

// *** dfas_mem_model.sv ***
`timescale 1ns/1ps
module dfas_mem_model import dfas_pkg::*; (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Request
  input  wire logic       mem_req,
  input  wire logic       mem_we,
  input  wire dfas_addr_t mem_addr,
  input  wire dfas_char_t mem_wdata,
  // Answer
  output logic            mem_ack,
  output dfas_char_t      mem_rdata,
  // Idle cycles before each answer
  input  wire logic [3:0] lat
);
  dfas_char_t mem [0:16383];
  logic [3:0] wait_r;

  // One answer per request, after lat idle cycles
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'b0;
      wait_r    <= 4'h0;
      mem_rdata <= 6'h15;
    end else if (mem_req && !mem_ack && wait_r >= lat) begin
      mem_ack <= 1'b1;
      wait_r  <= 4'h0;
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr];
      end
    end else begin
      // Read data not valid: keep it moving
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r    <= (mem_req && !mem_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// *** decimal_field_add_subtract_tb.sv ***
`timescale 1ns/1ps
`include "dfas_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module decimal_field_add_subtract_tb import dfas_pkg::*;;
  logic       mclk, arst_n, start, mem_req, mem_we, mem_ack;
  logic       busy, done, cond_zero, cond_minus, cond_carry, seen;
  logic [3:0] func_code, a_length_field, b_length_field, lat;
  dfas_addr_t a_addr, b_addr, mem_addr, first_addr;
  dfas_char_t mem_wdata, mem_rdata;
  int         err_total = 0;
  int         tests_run = 0;

  typedef struct {
    logic [3:0] fn;
    logic [3:0] la;
    logic [3:0] lb;
    longint     av;
    longint     bv;
    bit         as;
    bit         bs;
    logic [3:0] lt;
  } dfas_row_t;

  dfas_row_t rows [13] = '{
    '{`DFAS_FN_ADD, 4'h1, 4'h1, 2, 2, 0, 0, 4'h0},
    '{`DFAS_FN_ADD, 4'h1, 4'h1, 9, 3, 0, 0, 4'h1},
    '{`DFAS_FN_ADD, 4'h1, 4'h1, 9, 9, 0, 0, 4'h2},
    '{`DFAS_FN_ADD, 4'h0, 4'h0, 64'd9999999999, 1, 0, 0, 4'h0},
    '{`DFAS_FN_SUB, 4'h2, 4'h3, 12, 500, 0, 0, 4'h1},
    '{`DFAS_FN_SUB, 4'h3, 4'h3, 500, 12, 0, 0, 4'h0},
    '{`DFAS_FN_ADD, 4'h1, 4'h1, 7, 5, 1, 0, 4'h0},
    '{`DFAS_FN_SUB, 4'h2, 4'h2, 5, 7, 1, 0, 4'h0},
    '{`DFAS_FN_ADD, 4'h2, 4'h3, 45, 55, 1, 1, 4'h3},
    '{`DFAS_FN_ADD, 4'h4, 4'h2, 9999, 1, 0, 0, 4'h0},
    '{`DFAS_FN_ADD, 4'h3, 4'h2, 912, 7, 0, 0, 4'h1},
    '{`DFAS_FN_SUB, 4'h2, 4'h2, 35, 35, 1, 1, 4'h0},
    '{`DFAS_FN_SUB, 4'h0, 4'h0, 1, 0, 0, 0, 4'h0}
  };

  dfas_top u_dut (.mclk(mclk), .arst_n(arst_n), .start(start), .func_code(func_code),
    .a_length_field(a_length_field), .b_length_field(b_length_field), .a_addr(a_addr),
    .b_addr(b_addr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy),
    .done(done), .cond_zero(cond_zero), .cond_minus(cond_minus), .cond_carry(cond_carry));

  dfas_mem_model u_mem (.mclk(mclk), .arst_n(arst_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .lat(lat));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // First address asked for after each start
  always @(posedge mclk) begin
    if (mem_req && !seen) begin
      first_addr <= mem_addr;
      seen       <= 1'b1;
    end
  end

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic load(input dfas_addr_t ad, input int n, input longint v, input bit s);
    for (int j = n - 1; j >= 0; j--) begin
      u_mem.mem[14'(ad + j)] = {(j == n - 1) ? {s, 1'b0} : 2'(j + 1), 4'(v % 10)};
      v = v / 10;
    end
  endtask

  task automatic chk(input dfas_addr_t ad, input int n, input longint v, input bit s, input bit z);
    dfas_char_t e;
    for (int j = n - 1; j >= 0; j--) begin
      e = {(j == n - 1) ? {s, z} : 2'(j + 1), 4'(v % 10)};
      `CHK(u_mem.mem[14'(ad + j)], e)
      v = v / 10;
    end
  endtask

  task automatic start_op(input logic [3:0] fn, la, lb, input dfas_addr_t aa, ba);
    @(posedge mclk);
    start          <= 1'b1;
    func_code      <= fn;
    a_length_field <= la;
    b_length_field <= lb;
    a_addr         <= aa;
    b_addr         <= ba;
    seen           <= 1'b0;
    @(posedge mclk);
    start <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 4000) begin
        err_total++;
        $display("[ERR] %0t no completion", $time);
        finish_test();
      end
    end
    @(negedge mclk);
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
  endtask

  task automatic do_row(input int i);
    dfas_row_t  r;
    int         na, nb;
    longint     m, at, s, res;
    bit         sg, cy;
    dfas_addr_t aa, ba;
    r  = rows[i];
    na = (r.la == 4'h0) ? 10 : int'(r.la);
    nb = (r.lb == 4'h0) ? 10 : int'(r.lb);
    aa = (i == 3) ? 14'h3ffa : 14'(14'h0100 + i * 16);
    ba = 14'(14'h1000 + i * 16);
    lat <= r.lt;
    load(aa, na, r.av, r.as);
    load(ba, nb, r.bv, r.bs);
    m = 1;
    repeat (nb) m = m * 10;
    at = r.av % m;
    cy = 1'b0;
    if ((r.fn == `DFAS_FN_SUB) ^ r.as ^ r.bs) begin
      s = r.bv - at;
    end else begin
      s  = r.bv + at;
      cy = (s >= m);
    end
    res = (s < 0) ? -s : s % m;
    sg  = r.bs ^ (s < 0);
    start_op(r.fn, r.la, r.lb, aa, ba);
    wait_done();
    `CHK(first_addr, 14'(aa + na - 1))
    chk(ba, nb, res, sg, 1'b1);
    chk(aa, na, r.av, r.as, 1'b0);
    `CHK(cond_zero, res == 0)
    `CHK(cond_minus, sg && res != 0)
    `CHK(cond_carry, cy)
  endtask

  initial begin
    arst_n         = 1'b0;
    start          = 1'b0;
    func_code      = 4'h0;
    a_length_field = 4'h0;
    b_length_field = 4'h0;
    a_addr         = 14'h0000;
    b_addr         = 14'h0000;
    lat            = 4'h0;
    seen           = 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(mem_req | busy | done | cond_zero | cond_minus | cond_carry, 1'b0)
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 13; i++) do_row(i);
    // Digits above nine
    u_mem.mem[14'h0300] = 6'h08;
    u_mem.mem[14'h0310] = 6'h0e;
    start_op(`DFAS_FN_ADD, 4'h1, 4'h1, 14'h0300, 14'h0310);
    wait_done();
    `CHK(u_mem.mem[14'h0310], 6'h1c)
    `CHK(cond_carry, 1'b1)
    u_mem.mem[14'h0310] = 6'h0e;
    start_op(`DFAS_FN_SUB, 4'h1, 4'h1, 14'h0300, 14'h0310);
    wait_done();
    `CHK(u_mem.mem[14'h0310], 6'h16)
    `CHK(cond_carry, 1'b0)
    // Other function codes never start
    for (int c = 0; c < 16; c++) begin
      if (c != 4 && c != 7) begin
        start_op(4'(c), 4'h1, 4'h1, 14'h0300, 14'h0310);
        repeat (3) @(negedge mclk);
        `CHK(busy | mem_req, 1'b0)
      end
    end
    // Start while busy is ignored
    start_op(`DFAS_FN_ADD, 4'h1, 4'h1, 14'h0300, 14'h0310);
    start_op(`DFAS_FN_SUB, 4'h2, 4'h2, 14'h0400, 14'h0410);
    wait_done();
    `CHK(u_mem.mem[14'h0310], 6'h14)
    repeat (4) @(negedge mclk);
    `CHK(busy | mem_req, 1'b0)
    // Reset in mid operation
    start_op(`DFAS_FN_ADD, 4'h1, 4'h1, 14'h0300, 14'h0310);
    repeat (4) @(posedge mclk);
    arst_n <= 1'b0;
    @(negedge mclk);
    `CHK(mem_req | mem_we | busy | done, 1'b0)
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    do_row(5);
    finish_test();
  end
endmodule
